// File: rtl/card_regs_pkg.sv
// constants for the card command, response, crc and data register bank
// assumes a 32-bit apb slave at the bank's base address
package card_regs_pkg;
  localparam logic [31:0] response_word_0_off = 32'h15a0_0020;
  localparam logic [31:0] response_word_1_off = 32'h15a0_0024;
  localparam logic [31:0] response_word_2_off = 32'h15a0_0028;
  localparam logic [31:0] response_word_3_off = 32'h15a0_002c;
  localparam logic [31:0] command_first_byte_off = 32'h15a0_0030;
  localparam logic [31:0] command_arg_word_off = 32'h15a0_0034;
  localparam logic [31:0] read_crc_capture_off = 32'h15a0_0038;
  localparam logic [31:0] card_data_port_off = 32'h15a0_003c;
  localparam logic [31:0] card_status_reg_off = 32'h15a0_0040;
  localparam logic [31:0] irq_mask_off = 32'h15a0_0044;
  localparam logic [31:0] control_off = 32'h15a0_0048;
  localparam logic [31:0] word_reset = 32'h0000_0000;
  localparam logic [15:0] crc_reset = 16'h0000;
  localparam logic [7:0] byte_reset = 8'h00;
  localparam int crc_flag_bit = 5;
  localparam int resp_done_bit = 0;
  localparam int data_done_bit = 1;
  localparam int big_endian_bit = 0;
  localparam logic [7:0] status_reset = 8'h00;
  localparam int resp_bytes = 16;
  localparam int data_crc_bits = 16;
endpackage : card_regs_pkg

// File: rtl/card_cmd_resp_data_regs.sv
// command, response, read crc and data registers of the card host
// assumes apb on core_clk; card link clock and data arrive from pins
`timescale 1ns/10ps
`default_nettype none
module card_cmd_resp_data_regs (
  input wire logic core_clk,
  input wire logic rst_b,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic link_clk,
  input wire logic resp_in,
  input wire logic data_in,
  input wire logic data_crc_bad,
  output logic tx_byte_valid,
  output logic [7:0] tx_byte,
  output logic [7:0] cmd_first_byte,
  output logic [31:0] cmd_arg_word,
  output logic irq
);
  // link sampling: two flops then edge find
  logic [2:0] clk_sync_r;
  logic [1:0] resp_sync_r;
  logic [1:0] data_sync_r;
  logic [1:0] bad_sync_r;
  logic link_rise;
  assign link_rise = clk_sync_r[1] & ~clk_sync_r[2];

  always_ff @(posedge core_clk) begin
    if (!rst_b) begin
      clk_sync_r <= 3'h0;
      resp_sync_r <= 2'h3;
      data_sync_r <= 2'h3;
      bad_sync_r <= 2'h0;
    end else begin
      clk_sync_r <= {clk_sync_r[1:0], link_clk};
      resp_sync_r <= {resp_sync_r[0], resp_in};
      data_sync_r <= {data_sync_r[0], data_in};
      bad_sync_r <= {bad_sync_r[0], data_crc_bad};
    end
  end

  // response shift: start bit low, then 128 bits msb first
  logic [127:0] resp_shift_r;
  logic [7:0] resp_cnt_r;
  logic resp_busy_r;
  logic [127:0] resp_store_r;
  logic resp_done;
  logic resp_start;
  logic resp_last;
  logic [127:0] resp_frame;
  // count of the final response bit
  localparam logic [7:0] resp_last_cnt = 8'(card_regs_pkg::resp_bytes * 8 - 1);
  assign resp_start = link_rise & ~resp_busy_r & ~resp_sync_r[1];
  assign resp_last = resp_cnt_r == resp_last_cnt;
  assign resp_done = link_rise & resp_busy_r & resp_last;
  assign resp_frame = {resp_shift_r[126:0], resp_sync_r[1]};

  always_ff @(posedge core_clk) begin
    if (!rst_b) begin
      resp_busy_r <= 1'b0;
      resp_cnt_r <= 8'h00;
      resp_shift_r <= '0;
    end else if (link_rise) begin
      resp_shift_r <= resp_frame;
      if (resp_start) begin
        resp_busy_r <= 1'b1;
        resp_cnt_r <= 8'h00;
      end else if (resp_busy_r) begin
        resp_cnt_r <= resp_cnt_r + 8'h01;
        if (resp_last) begin
          resp_busy_r <= 1'b0;
        end
      end
    end
  end

  // lanes loaded only from the link
  always_ff @(posedge core_clk) begin
    if (!rst_b) begin
      resp_store_r <= '0;
    end else if (resp_done) begin
      resp_store_r <= resp_frame;
    end
  end

  // data receive: start bit, 8 bits, then 16 crc bits
  logic [23:0] dat_shift_r;
  logic [4:0] dat_cnt_r;
  logic dat_busy_r;
  logic [7:0] rx_byte_r;
  logic [15:0] crc_r;
  logic dat_byte_done;
  logic dat_crc_done;
  logic dat_start;
  logic dat_crc_last;
  logic [23:0] dat_frame;
  // counts of the final data bit and final crc bit
  localparam logic [4:0] dat_byte_last = 5'(8 - 1);
  localparam logic [4:0] dat_crc_last_cnt = 5'(8 + card_regs_pkg::data_crc_bits - 1);
  assign dat_start = link_rise & ~dat_busy_r & ~data_sync_r[1];
  assign dat_crc_last = dat_cnt_r == dat_crc_last_cnt;
  assign dat_byte_done = link_rise & dat_busy_r & (dat_cnt_r == dat_byte_last);
  assign dat_crc_done = link_rise & dat_busy_r & dat_crc_last;
  assign dat_frame = {dat_shift_r[22:0], data_sync_r[1]};

  always_ff @(posedge core_clk) begin
    if (!rst_b) begin
      dat_busy_r <= 1'b0;
      dat_cnt_r <= 5'h00;
      dat_shift_r <= '0;
    end else if (link_rise) begin
      dat_shift_r <= dat_frame;
      if (dat_start) begin
        dat_busy_r <= 1'b1;
        dat_cnt_r <= 5'h00;
      end else if (dat_busy_r) begin
        dat_cnt_r <= dat_cnt_r + 5'h01;
        if (dat_crc_last) begin
          dat_busy_r <= 1'b0;
        end
      end
    end
  end

  always_ff @(posedge core_clk) begin
    if (!rst_b) begin
      rx_byte_r <= card_regs_pkg::byte_reset;
      crc_r <= card_regs_pkg::crc_reset;
    end else begin
      if (dat_byte_done) begin
        rx_byte_r <= dat_frame[7:0];
      end
      if (dat_crc_done) begin
        crc_r <= dat_frame[15:0];
      end
    end
  end

  // apb decode
  logic acc;
  logic wr;
  logic rd;
  assign acc = psel & penable;
  assign wr = acc & pwrite;
  assign rd = acc & ~pwrite;
  assign pready = 1'b1;
  logic hit_r0, hit_r1, hit_r2, hit_r3, hit_c0, hit_c1, hit_crc, hit_dat;
  logic hit_sta, hit_msk, hit_ctl, mapped;
  // one register select from the full byte address
  function automatic logic addr_hit(input logic [31:0] a, input logic [31:0] off);
    addr_hit = a == off;
  endfunction : addr_hit
  assign hit_r0 = addr_hit(paddr, card_regs_pkg::response_word_0_off);
  assign hit_r1 = addr_hit(paddr, card_regs_pkg::response_word_1_off);
  assign hit_r2 = addr_hit(paddr, card_regs_pkg::response_word_2_off);
  assign hit_r3 = addr_hit(paddr, card_regs_pkg::response_word_3_off);
  assign hit_c0 = addr_hit(paddr, card_regs_pkg::command_first_byte_off);
  assign hit_c1 = addr_hit(paddr, card_regs_pkg::command_arg_word_off);
  assign hit_crc = addr_hit(paddr, card_regs_pkg::read_crc_capture_off);
  assign hit_dat = addr_hit(paddr, card_regs_pkg::card_data_port_off);
  assign hit_sta = addr_hit(paddr, card_regs_pkg::card_status_reg_off);
  assign hit_msk = addr_hit(paddr, card_regs_pkg::irq_mask_off);
  assign hit_ctl = addr_hit(paddr, card_regs_pkg::control_off);
  assign mapped = hit_r0 | hit_r1 | hit_r2 | hit_r3 | hit_c0 | hit_c1 | hit_crc | hit_dat
    | hit_sta | hit_msk | hit_ctl;
  assign pslverr = acc & ~mapped;
  // per-register write strobes
  logic wr_ctl, wr_c0, wr_c1, wr_dat, wr_sta, wr_msk;
  assign wr_ctl = wr & hit_ctl;
  assign wr_c0 = wr & hit_c0;
  assign wr_c1 = wr & hit_c1;
  assign wr_dat = wr & hit_dat;
  assign wr_sta = wr & hit_sta;
  assign wr_msk = wr & hit_msk;

  // lane order: little puts lowest-numbered byte in bits 7:0
  function automatic logic [31:0] lane_order(input logic [31:0] seq, input logic big);
    lane_order = big ? seq : {seq[7:0], seq[15:8], seq[23:16], seq[31:24]};
  endfunction : lane_order

  // control, command and data registers
  logic big_r;
  logic [7:0] cmd0_r;
  logic [31:0] cmd1_r;
  logic [7:0] tx_r;
  logic tx_valid_r;
  always_ff @(posedge core_clk) begin
    if (!rst_b) begin
      big_r <= 1'b0;
      cmd0_r <= card_regs_pkg::byte_reset;
      cmd1_r <= card_regs_pkg::word_reset;
      tx_r <= card_regs_pkg::byte_reset;
      tx_valid_r <= 1'b0;
    end else begin
      tx_valid_r <= wr_dat;
      if (wr_ctl) begin
        big_r <= pwdata[card_regs_pkg::big_endian_bit];
      end
      if (wr_c0) begin
        cmd0_r <= pwdata[7:0];
      end
      if (wr_c1) begin
        cmd1_r <= pwdata;
      end
      if (wr_dat) begin
        tx_r <= pwdata[7:0];
      end
    end
  end
  assign cmd_first_byte = cmd0_r;
  assign cmd_arg_word = lane_order(cmd1_r, big_r);
  assign tx_byte = tx_r;
  assign tx_byte_valid = tx_valid_r;

  // status: bit0 response done, bit1 data done, bit5 crc mismatch
  logic [7:0] sta_r;
  logic [7:0] msk_r;
  logic [7:0] sta_set;
  logic [7:0] sta_clr;
  logic [7:0] sta_wr_clr;
  logic sta_rd_clr;
  logic [7:0] sta_pend;
  assign sta_rd_clr = rd & hit_sta & sta_r[card_regs_pkg::crc_flag_bit];
  assign sta_wr_clr = wr_sta ? pwdata[7:0] : 8'h00;
  always_comb begin
    sta_set = 8'h00;
    sta_set[card_regs_pkg::resp_done_bit] = resp_done;
    sta_set[card_regs_pkg::data_done_bit] = dat_crc_done;
    sta_set[card_regs_pkg::crc_flag_bit] = dat_crc_done & bad_sync_r[1];
    sta_clr = sta_wr_clr;
    if (sta_rd_clr) begin
      sta_clr[card_regs_pkg::crc_flag_bit] = 1'b1;
    end
  end
  always_ff @(posedge core_clk) begin
    if (!rst_b) begin
      sta_r <= card_regs_pkg::status_reset;
      msk_r <= card_regs_pkg::status_reset;
    end else begin
      // set wins over a clear in the same cycle
      sta_r <= (sta_r & ~sta_clr) | sta_set;
      if (wr_msk) begin
        msk_r <= pwdata[7:0];
      end
    end
  end
  // level interrupt while any unmasked bit is set
  assign sta_pend = sta_r & msk_r;
  assign irq = |sta_pend;

  // read mux
  // lane order per word
  logic [31:0] rsp0, rsp1, rsp2, rsp3;
  assign rsp0 = lane_order(resp_store_r[127:96], big_r);
  assign rsp1 = lane_order(resp_store_r[95:64], big_r);
  assign rsp2 = lane_order(resp_store_r[63:32], big_r);
  assign rsp3 = lane_order(resp_store_r[31:0], big_r);
  // reads of these words change nothing, except a status read, which clears the bit5 crc mismatch flag
  logic [31:0] rd_cmd0, rd_crc, rd_dat, rd_sta, rd_msk, rd_ctl;
  assign rd_cmd0 = {24'h00_0000, cmd0_r};
  assign rd_crc = {16'h0000, crc_r};
  assign rd_dat = {24'h00_0000, rx_byte_r};
  assign rd_sta = {24'h00_0000, sta_r};
  assign rd_msk = {24'h00_0000, msk_r};
  assign rd_ctl = {31'h0000_0000, big_r};
  always_comb begin
    prdata = 32'h0000_0000;
    if (rd) begin
      if (hit_r0) prdata = rsp0;
      if (hit_r1) prdata = rsp1;
      if (hit_r2) prdata = rsp2;
      if (hit_r3) prdata = rsp3;
      if (hit_c0) prdata = rd_cmd0;
      if (hit_c1) prdata = cmd1_r;
      if (hit_crc) prdata = rd_crc;
      if (hit_dat) prdata = rd_dat;
      if (hit_sta) prdata = rd_sta;
      if (hit_msk) prdata = rd_msk;
      if (hit_ctl) prdata = rd_ctl;
    end
  end
endmodule : card_cmd_resp_data_regs
`default_nettype wire

// File: sim/card_regs_props.sv
// assertions on the card register bank ports
// assumes zero-wait apb, little endian after reset
`timescale 1ns/10ps
`default_nettype none
module card_regs_props (
  input wire logic core_clk,
  input wire logic rst_b,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pslverr,
  input wire logic tx_byte_valid,
  input wire logic [7:0] tx_byte,
  input wire logic [7:0] cmd_first_byte,
  input wire logic [31:0] cmd_arg_word,
  input wire logic irq
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_b);
  logic big_r;
  wire acc_w = psel & penable;
  wire wr_w = acc_w & pwrite;
  wire cmd0_w = wr_w && paddr == card_regs_pkg::command_first_byte_off;
  wire arg_w = wr_w && paddr == card_regs_pkg::command_arg_word_off;
  wire dat_w = wr_w && paddr == card_regs_pkg::card_data_port_off;
  wire ctl_w = wr_w && paddr == card_regs_pkg::control_off;
  wire map_w = paddr >= card_regs_pkg::response_word_0_off &&
    paddr <= card_regs_pkg::control_off && paddr[1:0] == 2'h0;
  wire [31:0] arg_exp = big_r ? pwdata :
    {pwdata[7:0], pwdata[15:8], pwdata[23:16], pwdata[31:24]};
  always_ff @(posedge core_clk)
    if (!rst_b) big_r <= 1'b0;
    else if (ctl_w) big_r <= pwdata[0];
  AST_CMD0_LOAD: assert property (cmd0_w |=> cmd_first_byte == $past(pwdata[7:0]))
    else $error("first command byte not loaded");
  AST_CMD0_HOLD: assert property (!cmd0_w |=> $stable(cmd_first_byte))
    else $error("first command byte changed");
  AST_ARG_LOAD: assert property (arg_w |=> cmd_arg_word == $past(arg_exp))
    else $error("command word lanes wrong");
  AST_ARG_HOLD: assert property (!arg_w && !ctl_w |=> $stable(cmd_arg_word))
    else $error("command word changed");
  AST_TX_PULSE: assert property (dat_w |=> tx_byte_valid && tx_byte == $past(pwdata[7:0])
    ##1 !tx_byte_valid)
    else $error("transmit byte pulse wrong");
  AST_TX_QUIET: assert property (!dat_w |=> !tx_byte_valid)
    else $error("stray transmit pulse");
  AST_RD_OK: assert property (acc_w && !pwrite && map_w |-> !pslverr)
    else $error("mapped read flagged");
  AST_UNMAPPED: assert property (acc_w && !map_w |-> pslverr && prdata == 32'h0000_0000)
    else $error("unmapped access not refused");
  cover property (arg_w);
  cover property (dat_w ##1 tx_byte_valid);
  cover property ($rose(irq));
endmodule : card_regs_props
bind card_cmd_resp_data_regs card_regs_props i_props (.core_clk, .rst_b, .psel,
  .penable, .pwrite, .paddr, .pwdata, .prdata, .pslverr, .tx_byte_valid,
  .tx_byte, .cmd_first_byte, .cmd_arg_word, .irq);
`default_nettype wire

// File: sim/card_model.sv
// card side model: link clock, response and data lines
// assumes lines idle high by pull-up, clock still between frames
`timescale 1ns/10ps
`default_nettype none
module card_model (
  output logic link_clk,
  output logic resp_in,
  output logic data_in,
  output logic data_crc_bad
);
  initial begin
    link_clk = 1'b0;
    resp_in = 1'b1;
    data_in = 1'b1;
    data_crc_bad = 1'b0;
  end
  // start bit then n bits msb first
  task automatic frame(input logic sel, input logic [151:0] v, input int n);
    for (int i = n; i >= 0; i--) begin
      if (sel) data_in = (i == n) ? 1'b0 : v[i];
      else resp_in = (i == n) ? 1'b0 : v[i];
      #62.5 link_clk = 1'b1;
      #62.5 link_clk = 1'b0;
    end
    resp_in = 1'b1;
    data_in = 1'b1;
  endtask : frame
  task automatic send_resp(input logic [127:0] r);
    frame(1'b0, {24'h00_0000, r}, 128);
  endtask : send_resp
  task automatic send_data(input logic [7:0] d, input logic [15:0] c, input logic bad);
    data_crc_bad = bad;
    frame(1'b1, {128'h0, d, c}, 24);
    #100 data_crc_bad = 1'b0;
  endtask : send_data
endmodule : card_model
`default_nettype wire

// File: sim/testbench.sv
// self-checking bench for the card register bank
// assumes the card model drives the link lines
`timescale 1ns/10ps
`default_nettype none
module testbench;
  logic core_clk = 1'b0;
  logic rst_b = 1'b0;
  logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [31:0] paddr = 32'h0000_0000, pwdata = 32'h0000_0000;
  logic [31:0] rd, exp_v, nil = 32'h0000_0000;
  logic [127:0] resp;
  logic err;
  int fail_count = 0, samples_checked = 0;
  wire [31:0] prdata, cmd_arg_word;
  wire [7:0] tx_byte, cmd_first_byte;
  wire pready, pslverr, link_clk, resp_in, data_in, data_crc_bad, tx_byte_valid, irq;
  always #4 core_clk = ~core_clk;
  card_cmd_resp_data_regs i_card_cmd_resp_data_regs (.core_clk, .rst_b, .psel,
    .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .link_clk,
    .resp_in, .data_in, .data_crc_bad, .tx_byte_valid, .tx_byte,
    .cmd_first_byte, .cmd_arg_word, .irq);
  card_model card (.link_clk, .resp_in, .data_in, .data_crc_bad);
  task automatic wrap_up;
    $display("fails %0d checks %0d", fail_count, samples_checked);
    if (fail_count == 0 && samples_checked > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask : wrap_up
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] want);
    samples_checked++;
    if (seen !== want) begin
      fail_count++;
      $display("[FAIL] %s expected %h seen %h", nm, want, seen);
    end
  endtask : chk
  task automatic apb(input logic w, input logic [31:0] a, input logic [31:0] d);
    @(posedge core_clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge core_clk);
    penable <= 1'b1;
    for (int i = 0; i < 9; i++) begin
      @(posedge core_clk);
      if (pready === 1'b1) begin
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        return;
      end
    end
    fail_count++;
    wrap_up();
  endtask : apb
  task automatic wait_irq;
    for (int i = 0; i < 60; i++) begin
      @(posedge core_clk);
      if (irq === 1'b1) return;
    end
    fail_count++;
    wrap_up();
  endtask : wait_irq
  initial begin
    repeat (10) @(posedge core_clk);
    rst_b <= 1'b1;
    for (int k = 0; k < 8; k++) begin
      apb(1'b0, card_regs_pkg::response_word_0_off + 32'(4 * k), nil);
      chk("reset", rd, nil);
    end
    apb(1'b1, card_regs_pkg::command_first_byte_off, 32'h1234_56a5);
    apb(1'b0, card_regs_pkg::command_first_byte_off, nil);
    chk("cmd0", rd, 32'h0000_00a5);
    apb(1'b1, card_regs_pkg::response_word_0_off, 32'hffff_ffff);
    apb(1'b0, card_regs_pkg::response_word_0_off, nil);
    chk("ro write", rd, nil);
    apb(1'b0, 32'h15a0_0050, nil);
    chk("unmapped", {31'h0000_0000, err}, 32'h0000_0001);
    apb(1'b1, card_regs_pkg::irq_mask_off, 32'h0000_0023);
    for (int m = 0; m < 2; m++) begin
      apb(1'b1, card_regs_pkg::control_off, 32'(m));
      apb(1'b1, card_regs_pkg::command_arg_word_off, 32'h0102_0304);
      #1 chk("arg out", cmd_arg_word, m ? 32'h0102_0304 : 32'h0403_0201);
      apb(1'b0, card_regs_pkg::command_arg_word_off, nil);
      chk("arg rd", rd, 32'h0102_0304);
      for (int b = 0; b < 16; b++) resp[127 - 8 * b -: 8] = 8'(b + 1 + 16 * m);
      card.send_resp(resp);
      wait_irq();
      apb(1'b0, card_regs_pkg::card_status_reg_off, nil);
      chk("resp done", rd, 32'h0000_0001);
      apb(1'b1, card_regs_pkg::card_status_reg_off, 32'h0000_0001);
      for (int n = 0; n < 8; n++) begin
        for (int l = 0; l < 4; l++) begin
          exp_v[(m ? 31 - 8 * l : 7 + 8 * l) -: 8] = 8'(4 * (n % 4) + l + 1 + 16 * m);
        end
        apb(1'b0, card_regs_pkg::response_word_0_off + 32'(4 * (n % 4)), nil);
        chk("resp", rd, exp_v);
      end
    end
    card.send_data(8'h5a, 16'hbeef, 1'b1);
    wait_irq();
    apb(1'b0, card_regs_pkg::card_data_port_off, nil);
    chk("rx byte", rd, 32'h0000_005a);
    apb(1'b0, card_regs_pkg::read_crc_capture_off, nil);
    chk("crc", rd, 32'h0000_beef);
    apb(1'b1, card_regs_pkg::irq_mask_off, nil);
    #1 chk("masked", {31'h0000_0000, irq}, nil);
    apb(1'b0, card_regs_pkg::card_status_reg_off, nil);
    chk("crc flag", rd, 32'h0000_0022);
    apb(1'b0, card_regs_pkg::card_status_reg_off, nil);
    chk("flag read", rd, 32'h0000_0002);
    apb(1'b1, card_regs_pkg::irq_mask_off, 32'h0000_0020);
    card.send_data(8'h3c, 16'h1234, 1'b1);
    wait_irq();
    apb(1'b1, card_regs_pkg::card_status_reg_off, 32'h0000_0020);
    apb(1'b0, card_regs_pkg::card_status_reg_off, nil);
    chk("flag w1c", rd, 32'h0000_0002);
    apb(1'b0, card_regs_pkg::card_data_port_off, nil);
    chk("rx byte 2", rd, 32'h0000_003c);
    apb(1'b0, card_regs_pkg::read_crc_capture_off, nil);
    chk("crc 2", rd, 32'h0000_1234);
    apb(1'b1, card_regs_pkg::card_data_port_off, 32'h0000_00c3);
    #1 chk("tx", {23'h00_0000, tx_byte_valid, tx_byte}, 32'h0000_01c3);
    wrap_up();
  end
endmodule : testbench
`default_nettype wire
